// >>> bench/smc_mon_asserts.sv
/* Port checker of the supply monitor control block.
   Assumes it is bound into smc_supply_monitor. */
`timescale 1ns/1ps
module smc_mon_asserts #(
	parameter int unsigned HOLD_CYCLES = 50
) (
	input logic clk_i,
	input logic srst_i,
	input logic [7:0] addr_i,
	input logic [7:0] wdata_i,
	input logic wr_i,
	input logic rd_i,
	input logic [7:0] rdata_o,
	input logic digital_rail_comparator_i,
	input logic analog_rail_comparator_i,
	input logic [1:0] digital_trip_select_o,
	input logic [1:0] analog_trip_select_o,
	input logic monitor_enable_o,
	input logic low_supply_flag_o,
	input logic irq_o
);
	// ------------------------------------------------------------
	// Run counters; good_q and low_q saturate so long runs never wrap, flag_q counts freely
	// ------------------------------------------------------------
	logic ok;
	logic [4:0] good_q;
	logic [5:0] low_q;
	logic [31:0] flag_q;
	assign ok = !monitor_enable_o || (digital_rail_comparator_i && analog_rail_comparator_i);
	always_ff @(posedge clk_i) good_q <= srst_i ? 5'h1F : (!ok ? 5'h00 : good_q + 5'(good_q != 5'h1F));
	always_ff @(posedge clk_i) low_q <= (srst_i || ok) ? 6'h00 : low_q + 6'(low_q != 6'h3F);
	always_ff @(posedge clk_i) flag_q <= (srst_i || !low_supply_flag_o) ? 32'h0 : flag_q + 32'h1;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("rdata not idle");
	a_ctrl_read: assert property (rd_i && addr_i == 8'hDF |=> rdata_o[4:0] ==
		{digital_trip_select_o, analog_trip_select_o, monitor_enable_o}) else $error("ctrl read");
	a_ctrl_write: assert property (wr_i && addr_i == 8'hDF |=> $past(wdata_i[4:0]) ==
		{digital_trip_select_o, analog_trip_select_o, monitor_enable_o}) else $error("ctrl write");
	a_cmp_off: assert property (rd_i && addr_i == 8'hDF && !monitor_enable_o
		|=> rdata_o[7:6] == 2'h3) else $error("cmp bits when off");
	a_glitch_block: assert property ($rose(low_supply_flag_o) && !$past(wr_i)
		|-> good_q < 5'h14) else $error("flag on good rails");
	a_hold_time: assert property ($fell(low_supply_flag_o) && !$past(wr_i) && !$past(srst_i)
		|-> flag_q >= HOLD_CYCLES - 1) else $error("hold too short");
	a_clear_refused: assert property (wr_i && addr_i == 8'hDF && wdata_i[0] && !wdata_i[5]
		&& low_supply_flag_o && low_q > 6'h1E |=> low_supply_flag_o) else $error("clear taken");
	a_irq_masked: assert property (wr_i && addr_i == 8'hE1 && wdata_i[1:0] == 2'h0
		|=> !irq_o) else $error("irq while masked");
endmodule : smc_mon_asserts
bind smc_supply_monitor smc_mon_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_asserts (
	.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .digital_rail_comparator_i(digital_rail_comparator_i),
	.analog_rail_comparator_i(analog_rail_comparator_i),
	.digital_trip_select_o(digital_trip_select_o), .analog_trip_select_o(analog_trip_select_o),
	.monitor_enable_o(monitor_enable_o), .low_supply_flag_o(low_supply_flag_o), .irq_o(irq_o)
);

// >>> bench/smc_rail_model.sv
/* Behavioural model of the two rail comparators.
   Assumes rail levels given by the bench as trip codes. */
`timescale 1ns/1ps
module smc_rail_model (
	input logic [1:0] digital_level_i,
	input logic [1:0] analog_level_i,
	input logic [1:0] digital_trip_select_i,
	input logic [1:0] analog_trip_select_i,
	output logic digital_rail_comparator_o,
	output logic analog_rail_comparator_o
);
	// Level c sits just above trip c; a higher code is a lower voltage
	assign digital_rail_comparator_o = digital_level_i <= digital_trip_select_i;
	assign analog_rail_comparator_o = analog_level_i <= analog_trip_select_i;
endmodule : smc_rail_model

// >>> bench/tb_top.sv
/* Self-checking bench of the supply monitor control block.
   Assumes the rail model and the bound port checker. */
`timescale 1ns/1ps
`include "smc_regs.svh"
module tb_top;
	localparam int unsigned HOLD = 50;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [1:0] dlv = 2'h0;
	logic [1:0] alv = 2'h0;
	logic [7:0] rdata;
	logic [1:0] dtrip, atrip;
	logic dcmp, acmp, en, flag, irq;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	smc_supply_monitor #(.HOLD_CYCLES(HOLD)) u_dut (
		.clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .digital_rail_comparator_i(dcmp),
		.analog_rail_comparator_i(acmp), .digital_trip_select_o(dtrip),
		.analog_trip_select_o(atrip), .monitor_enable_o(en),
		.low_supply_flag_o(flag), .irq_o(irq)
	);
	smc_rail_model u_rails (
		.digital_level_i(dlv), .analog_level_i(alv), .digital_trip_select_i(dtrip),
		.analog_trip_select_i(atrip), .digital_rail_comparator_o(dcmp),
		.analog_rail_comparator_o(acmp)
	);
	initial forever #50 clk = ~clk;
	// Cuts a hang short; the whole run needs about 340 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk("rdata", e, rdata);
	endtask : rreg
	// Bounded wait so a stuck flag ends in a mismatch, not a hang
	task automatic waitf(input logic v);
		n = 0;
		while (flag !== v && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("flag", {7'h0, v}, {7'h0, flag});
	endtask : waitf
	task automatic close_out;
		if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		rreg(`SMC_ADDR_CTRL, `SMC_CTRL_RESET);
		chk("outs", 8'h1E, {3'h0, dtrip, atrip, en});
		for (int c = 0; c < 4; c++) begin
			wreg(`SMC_ADDR_CTRL, 8'(c * 10 + 1));
			rreg(`SMC_ADDR_CTRL, 8'hC0 | 8'(c * 10 + 1));
			chk("outs", 8'(c * 10 + 1), {3'h0, dtrip, atrip, en});
		end
		wreg(`SMC_ADDR_CTRL, 8'h01);
		rreg(8'h10, 8'h00);
		wreg(`SMC_ADDR_IRQ_MASK, 8'h03);
		alv <= 2'h1;
		repeat (10) @(posedge clk);
		alv <= 2'h0;
		repeat (40) @(posedge clk);
		chk("glitch", 8'h00, {6'h0, flag, irq});
		dlv <= 2'h1;
		waitf(1'h1);
		repeat (8) @(posedge clk);
		rreg(`SMC_ADDR_CTRL, 8'h61);
		chk("irq", 8'h01, {7'h0, irq});
		wreg(`SMC_ADDR_CTRL, 8'h01);
		rreg(`SMC_ADDR_CTRL, 8'h61);
		dlv <= 2'h0;
		repeat (30) @(posedge clk);
		dlv <= 2'h1;
		repeat (40) @(posedge clk);
		dlv <= 2'h0;
		waitf(1'h0);
		chk("hold", 8'h01, {7'h0, n >= HOLD + 20 && n <= HOLD + 30});
		rreg(`SMC_ADDR_IRQ_STATUS, 8'h03);
		wreg(`SMC_ADDR_IRQ_STATUS, 8'h03);
		rreg(`SMC_ADDR_IRQ_STATUS, 8'h00);
		wreg(`SMC_ADDR_IRQ_MASK, 8'h00);
		wreg(`SMC_ADDR_CTRL, 8'h21);
		repeat (3) @(posedge clk);
		chk("masked", 8'h02, {6'h0, flag, irq});
		wreg(`SMC_ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq", 8'h01, {7'h0, irq});
		wreg(`SMC_ADDR_CTRL, 8'h01);
		rreg(`SMC_ADDR_CTRL, 8'hC1);
		wreg(`SMC_ADDR_CTRL, 8'h00);
		alv <= 2'h1;
		repeat (40) @(posedge clk);
		rreg(`SMC_ADDR_CTRL, 8'hC0);
		alv <= 2'h0;
		close_out();
	end
endmodule : tb_top

// >>> core/smc_pkg.sv
/*
 * Types of the supply monitor control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package smc_pkg;

	// ------------------------------------------------------------------
	// Flag state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SMC_IDLE,
		SMC_LOW,
		SMC_HOLD
	} smc_state_e;

endpackage : smc_pkg

// >>> core/smc_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * supply monitor control block.
 * Assumes a 10 MHz core clock and an 8-bit register address space.
 */
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SMC_ADDR_CTRL 8'hDF
`define SMC_ADDR_IRQ_STATUS 8'hE0
`define SMC_ADDR_IRQ_MASK 8'hE1

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SMC_BIT_DCMP 7
`define SMC_BIT_ACMP 6
`define SMC_BIT_FLAG 5
`define SMC_BIT_DTRIP_HI 4
`define SMC_BIT_DTRIP_LO 3
`define SMC_BIT_ATRIP_HI 2
`define SMC_BIT_ATRIP_LO 1
`define SMC_BIT_EN 0
`define SMC_CTRL_RESET 8'hDE

// ----------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------
`define SMC_IRQ_LOW 0
`define SMC_IRQ_RECOVER 1
`define SMC_IRQ_W 2
`define SMC_IRQ_RESET 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SMC_CLK_HZ 10000000
`define SMC_HOLD_MS 250
`define SMC_HOLD_CYCLES ((64'd`SMC_HOLD_MS * 64'd`SMC_CLK_HZ) / 64'd1000)
`define SMC_HOLD_CNT_W 22
`define SMC_GLITCH_NS 2000
`define SMC_GLITCH_CYCLES ((`SMC_GLITCH_NS * (`SMC_CLK_HZ / 1000000)) / 1000)
`define SMC_GLITCH_CNT_W 5

`endif

// >>> core/smc_supply_monitor.sv
/*
 * Digital control and status of a dual-rail supply monitor: control
 * register, comparator input filtering, low-supply flag with recovery
 * hold-off, interrupt status and mask.
 * Assumes comparator outputs arrive asynchronously from the analog
 * section and that the register master follows the plain strobe port.
 */
// Summary of operation
// - A low-supply flag is raised when either rail drops below its selected trip point.
// - The flag drives the interrupt output when its enable bit is set.
// - The flag stays set until both rails have been good for 250 ms without a break, or software clears it once the rails are good.
// - Bits 7 and 6 read back the digital and analog comparator states, 1 meaning good.
// - Bit 5 is the low-supply flag, set by hardware whenever a comparator reads low.
// - With both comparators high a 250 ms counter runs and clears the flag on expiry.
// - Software may write the flag, but a clear is ignored while a comparator is low.
// - Bits 4:3 choose the digital trip level and are driven to its comparator.
// - Bits 2:1 choose the analog trip level with the same encoding.
// - Bit 0 enables the monitor when set and disables it when cleared.
// - The control register sits at address DF hex and resets to DE hex.
// - Comparator inputs are filtered so short glitches cannot set the flag.
`timescale 1ns/1ps
`include "smc_regs.svh"

module smc_supply_monitor #(
	parameter int unsigned HOLD_CYCLES = 32'(`SMC_HOLD_CYCLES)
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic digital_rail_comparator_i,
	input wire logic analog_rail_comparator_i,
	output logic [1:0] digital_trip_select_o,
	output logic [1:0] analog_trip_select_o,
	output logic monitor_enable_o,
	output logic low_supply_flag_o,
	output logic irq_o
);

	// ------------------------------------------------------------------
	// Constants and decode
	// ------------------------------------------------------------------
	localparam logic [`SMC_HOLD_CNT_W-1:0] HOLD_LAST = `SMC_HOLD_CNT_W'(HOLD_CYCLES - 1);
	localparam logic [`SMC_GLITCH_CNT_W-1:0] GLITCH_LAST =
		`SMC_GLITCH_CNT_W'(`SMC_GLITCH_CYCLES - 1);
	localparam logic [7:0] CTRL_RESET = `SMC_CTRL_RESET;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;
	assign wr_ctrl = wr_i && hit(addr_i, `SMC_ADDR_CTRL);
	assign wr_status = wr_i && hit(addr_i, `SMC_ADDR_IRQ_STATUS);
	assign wr_mask = wr_i && hit(addr_i, `SMC_ADDR_IRQ_MASK);

	// ------------------------------------------------------------------
	// Comparator synchronise and glitch filter
	// ------------------------------------------------------------------
	logic [1:0] cmp_raw;
	logic [1:0] cmp_filt;
	assign cmp_raw = {digital_rail_comparator_i, analog_rail_comparator_i};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_rail
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic filt_q;
			logic [`SMC_GLITCH_CNT_W-1:0] cnt_q;

			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					s1_q <= 1'b1;
					s2_q <= 1'b1;
					s3_q <= 1'b1;
				end else begin
					s1_q <= cmp_raw[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end

			// A new level must hold for the whole filter time before it counts
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					cnt_q <= '0;
					filt_q <= 1'b1;
				end else if (s2_q == s3_q && s3_q != filt_q) begin
					if (cnt_q == GLITCH_LAST) begin
						filt_q <= s3_q;
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end else begin
					cnt_q <= '0;
				end
			end

			assign cmp_filt[g] = filt_q;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	logic [1:0] dtrip_q;
	logic [1:0] atrip_q;
	logic enable_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dtrip_q <= CTRL_RESET[`SMC_BIT_DTRIP_HI:`SMC_BIT_DTRIP_LO];
			atrip_q <= CTRL_RESET[`SMC_BIT_ATRIP_HI:`SMC_BIT_ATRIP_LO];
			enable_q <= CTRL_RESET[`SMC_BIT_EN];
		end else if (wr_ctrl) begin
			dtrip_q <= wdata_i[`SMC_BIT_DTRIP_HI:`SMC_BIT_DTRIP_LO];
			atrip_q <= wdata_i[`SMC_BIT_ATRIP_HI:`SMC_BIT_ATRIP_LO];
			enable_q <= wdata_i[`SMC_BIT_EN];
		end
	end

	assign digital_trip_select_o = dtrip_q;
	assign analog_trip_select_o = atrip_q;
	assign monitor_enable_o = enable_q;

	// Disabled monitor reads both rails as good so no stale low can hold the flag
	logic dgood;
	logic agood;
	logic low_any;
	assign dgood = cmp_filt[1] | ~enable_q;
	assign agood = cmp_filt[0] | ~enable_q;
	assign low_any = ~dgood | ~agood;

	// ------------------------------------------------------------------
	// Low-supply flag and recovery hold-off
	// ------------------------------------------------------------------
	smc_pkg::smc_state_e state_q;
	smc_pkg::smc_state_e state_d;
	logic [`SMC_HOLD_CNT_W-1:0] hold_q;
	logic sw_set;
	logic sw_clear;
	logic expire;

	assign sw_set = wr_ctrl && wdata_i[`SMC_BIT_FLAG];
	assign sw_clear = wr_ctrl && !wdata_i[`SMC_BIT_FLAG];
	assign expire = (state_q == smc_pkg::SMC_HOLD) && !low_any && (hold_q == HOLD_LAST);

	always_comb begin
		state_d = state_q;
		case (state_q)
			smc_pkg::SMC_IDLE: begin
				if (low_any) begin
					state_d = smc_pkg::SMC_LOW;
				end else if (sw_set) begin
					state_d = smc_pkg::SMC_HOLD;
				end
			end
			smc_pkg::SMC_LOW: begin
				// Clears from software have no effect here
				if (!low_any) begin
					state_d = smc_pkg::SMC_HOLD;
				end
			end
			smc_pkg::SMC_HOLD: begin
				if (low_any) begin
					state_d = smc_pkg::SMC_LOW;
				end else if (sw_clear || expire) begin
					state_d = smc_pkg::SMC_IDLE;
				end
			end
			default: begin
				state_d = smc_pkg::SMC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= smc_pkg::SMC_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Counter only runs while both rails stay good
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hold_q <= '0;
		end else if (state_q == smc_pkg::SMC_HOLD && state_d == smc_pkg::SMC_HOLD) begin
			hold_q <= hold_q + 1'b1;
		end else begin
			hold_q <= '0;
		end
	end

	logic flag;
	assign flag = (state_q != smc_pkg::SMC_IDLE);
	assign low_supply_flag_o = flag;

	// ------------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------------
	logic [`SMC_IRQ_W-1:0] status_q;
	logic [`SMC_IRQ_W-1:0] mask_q;
	logic [`SMC_IRQ_W-1:0] events;

	always_comb begin
		events = '0;
		events[`SMC_IRQ_LOW] = flag;
		events[`SMC_IRQ_RECOVER] = expire;
	end

	// Set wins over a same-cycle write-one clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_q <= `SMC_IRQ_RESET;
		end else begin
			status_q <= (status_q & ~(wr_status ? wdata_i[`SMC_IRQ_W-1:0] : '0)) | events;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mask_q <= `SMC_IRQ_RESET;
		end else if (wr_mask) begin
			mask_q <= wdata_i[`SMC_IRQ_W-1:0];
		end
	end

	assign irq_o = |(status_q & mask_q);

	// ------------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] ctrl_view;
	assign ctrl_view = {dgood, agood, flag, dtrip_q, atrip_q, enable_q};

	// Data stands only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i && hit(addr_i, `SMC_ADDR_CTRL)) begin
			rdata_q <= ctrl_view;
		end else if (rd_i && hit(addr_i, `SMC_ADDR_IRQ_STATUS)) begin
			rdata_q <= {6'h00, status_q};
		end else if (rd_i && hit(addr_i, `SMC_ADDR_IRQ_MASK)) begin
			rdata_q <= {6'h00, mask_q};
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o = rdata_q;

endmodule : smc_supply_monitor
